// ===== bbe_exec.sv
// execute unit for relative branch and bit set in register
`timescale 1ns/100ps
`include "bbe_params.svh"
module bbe_exec (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] opcode,
    input wire logic ext_set_en,
    input wire logic [3:0] bank_pointer,
    input wire logic [11:0] fsr_base,
    input wire logic [7:0] file_rdata,
    output logic [1:0] q_phase,
    output logic [20:0] pc,
    output logic discard,
    output bbe_pkg::bbe_file_t file_port
);
    import bbe_pkg::*;

    // ====================
    // helpers
    // sign-extend and double the 11-bit offset
    function automatic logic [20:0] bbe_offset(input logic [15:0] op);
        logic [20:0] ext;
        ext = {{10{op[`BBE_OFF_MSB]}}, op[`BBE_OFF_MSB:0]};
        return {ext[19:0], 1'b0};
    endfunction

    // file address select: indexed, access bank or banked
    function automatic logic [11:0] bbe_addr(input logic [15:0] op, input logic ext,
                                             input logic [3:0] bank, input logic [11:0] base);
        if (ext && !op[`BBE_ACC_BIT] && op[7:0] <= `BBE_IDX_LIMIT) begin
            return 12'(base + {4'h0, op[7:0]});
        end else if (op[`BBE_ACC_BIT]) begin
            return {bank, op[7:0]};
        end else begin
            return {4'h0, op[7:0]};
        end
    endfunction

    bbe_regs_t r; // current state
    bbe_regs_t next_r; // next state
    logic is_bra; // branch decode
    logic is_bsf; // bit-set decode

    // ====================
    // next state
    always_comb begin
        next_r = r;
        is_bra = (r.ir[15:12] == `BBE_OP_BRANCH) && (r.ir[11] == 1'b0);
        is_bsf = (r.ir[15:12] == `BBE_OP_BITSET);
        next_r.q = 2'(r.q + 2'h1);
        next_r.file.rd = 1'b0;
        next_r.file.wr = 1'b0;
        case (r.q)
            `BBE_Q1: begin
                // capture fetched word and advance pc past it
                next_r.ir = opcode;
                next_r.pc = 21'(r.pc + `BBE_PC_STEP);
            end
            `BBE_Q2: begin
                if (r.st == BBE_RUN && is_bsf) begin
                    next_r.file.rd = 1'b1;
                    next_r.file.addr = bbe_addr(r.ir, ext_set_en, bank_pointer, fsr_base);
                end
            end
            `BBE_Q3: begin
                if (r.st == BBE_RUN && is_bsf) begin
                    // set the chosen bit only, no status touched
                    next_r.data = file_rdata | (8'h01 << r.ir[11:`BBE_BIT_LSB]);
                end
            end
            `BBE_Q4: begin
                next_r.flush = 1'b0;
                next_r.st = BBE_RUN;
                if (r.st == BBE_FLUSH) begin
                    // second cycle is a no-op
                    next_r.st = BBE_RUN;
                end else if (is_bra) begin
                    next_r.pc = 21'(r.pc + bbe_offset(r.ir));
                    next_r.st = BBE_FLUSH;
                    next_r.flush = 1'b1;
                end else if (is_bsf) begin
                    next_r.file.wr = 1'b1;
                    next_r.file.wdata = r.data;
                end
            end
            default: begin
                next_r.q = `BBE_Q1;
            end
        endcase
    end

    // ====================
    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.pc <= `BBE_PC_RESET;
            r.q <= `BBE_Q1;
            r.st <= BBE_RUN;
        end else begin
            r <= next_r;
        end
    end

    // ====================
    // outputs
    assign q_phase = r.q;
    assign pc = r.pc;
    assign discard = r.flush;
    assign file_port = r.file;
endmodule

// ===== bbe_params.svh
// constants for the branch and bit-set execute block
`ifndef BBE_PARAMS_SVH
`define BBE_PARAMS_SVH
// ====================
// opcode fields
`define BBE_OP_BRANCH 4'hd
`define BBE_OP_BITSET 4'h8
`define BBE_OFF_MSB 10
`define BBE_BIT_LSB 9
`define BBE_ACC_BIT 8
`define BBE_IDX_LIMIT 8'h5f
// ====================
// quarter phases, pc reset value and pc step
`define BBE_Q1 2'h0
`define BBE_Q2 2'h1
`define BBE_Q3 2'h2
`define BBE_Q4 2'h3
`define BBE_PC_RESET 21'h000000
`define BBE_PC_STEP 21'h000002
`endif

// ===== bbe_pkg.sv
// types for the branch and bit-set execute block
package bbe_pkg;
    // execution state along the two-cycle branch path
    typedef enum logic [1:0] {
        BBE_RUN = 2'h0,
        BBE_FLUSH = 2'h1
    } bbe_state_t;

    // register file access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } bbe_file_t;

    // whole module state
    typedef struct packed {
        bbe_state_t st;
        logic [1:0] q;
        logic [20:0] pc;
        logic [15:0] ir;
        logic [7:0] data;
        logic flush;
        bbe_file_t file;
    } bbe_regs_t;
endpackage

// ===== bbe_exec_props.sv
// execute block checker
`timescale 1ns/100ps
module bbe_exec_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] opcode,
    input wire logic [1:0] q_phase,
    input wire logic [20:0] pc,
    input wire logic discard,
    input wire bbe_pkg::bbe_file_t file_port
);
    import bbe_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    br_target_a: assert property (q_phase == 2'h0 && !discard && opcode[15:11] == 5'h1a |-> ##4
        pc == 21'($past(pc, 4) + 21'h2 + {{9{$past(opcode[10], 4)}}, $past(opcode[10:0], 4), 1'b0}))
        else $error("pc");
    br_flush_a: assert property (q_phase == 2'h0 && !discard && opcode[15:11] == 5'h1a |-> ##4 $rose(discard))
        else $error("flush");
    flush_len_a: assert property ($rose(discard) |-> discard [*4] ##1 !discard) else $error("len");
    set_cycle_a: assert property (q_phase == 2'h0 && !discard && opcode[15:12] == 4'h8 |-> ##2 file_port.rd
        ##2 file_port.wr) else $error("cycle");
    wr_addr_a: assert property (file_port.wr |-> file_port.addr == $past(file_port.addr, 2)) else $error("addr");
    wr_pulse_a: assert property (file_port.wr |=> !file_port.wr) else $error("pulse");
endmodule

// ===== bbe_regfile_model.sv
// register file model
`timescale 1ns/100ps
module bbe_regfile_model (
    input wire bbe_pkg::bbe_file_t file_port,
    output logic [7:0] file_rdata
);
    import bbe_pkg::*;
    // reads back a pattern tied to the address
    assign file_rdata = file_port.addr[7:0] ^ 8'h5a;
endmodule

// ===== bbe_exec_tb.sv
// execute block bench
`timescale 1ns/100ps
module bbe_exec_tb;
    import bbe_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic [16:0] cfg = 17'h00000;
    logic [7:0] file_rdata;
    logic [1:0] q_phase;
    bbe_file_t file_port;
    logic [19:0] exp_q[$];
    logic [20:0] pc_w; // program counter seen
    logic discard; // flush flag seen
    logic disc_d = 1'b0; // flush flag one negedge ago
    logic [20:0] exp_pc = 21'h000002; // address of the next bench instruction
    logic [20:0] pc_q[$]; // expected branch targets
    int error_cnt = 0, comparisons = 0;
    always #4 ref_clk = ~ref_clk;
    bbe_exec dut_u (.ref_clk, .rst_n, .opcode, .ext_set_en(cfg[4]), .bank_pointer(cfg[3:0]),
        .fsr_base(cfg[16:5]), .file_rdata, .q_phase, .pc(pc_w), .discard(discard), .file_port);
    bbe_regfile_model mdl_u (.file_port, .file_rdata);
    task automatic tally_and_finish;
        $display("%0d errors in %0d checks", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp_wr(input logic [19:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error write expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_pc(input logic [20:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("Error pc expected %h seen %h", e, g);
        end
    endtask
    task automatic run(input logic [15:0] op);
        logic [16:0] r;
        logic [11:0] a;
        r = 17'($urandom);
        a = op[8] ? {r[3:0], op[7:0]} : {4'h0, op[7:0]};
        if (!op[8] && r[4] && op[7:0] <= 8'h5f)
            a = r[16:5] + {4'h0, op[7:0]};
        if (op[15:12] == 4'h8)
            exp_q.push_back({a, (a[7:0] ^ 8'h5a) | (8'h01 << op[11:9])});
        if (op[15:11] == 5'h1a) begin
            exp_pc = 21'(exp_pc + 21'h000002 + {{9{op[10]}}, op[10:0], 1'b0});
            pc_q.push_back(exp_pc);
        end else begin
            exp_pc = 21'(exp_pc + 21'h000002);
        end
        opcode <= op;
        cfg <= r;
        repeat (4) @(posedge ref_clk);
    endtask
    always @(negedge ref_clk)
        if (file_port.wr === 1'b1)
            cmp_wr(exp_q.pop_front(), {file_port.addr, file_port.wdata});
    always @(negedge ref_clk) begin
        disc_d <= discard;
        if (discard === 1'b1 && disc_d !== 1'b1)
            cmp_pc(pc_q.pop_front(), pc_w);
    end
    initial begin
        repeat (900) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(35846));
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk iff q_phase == 2'h3);
        for (int i = 0; i < 44; i++)
            run(i < 40 ? {4'h8, i[3:0], 8'($urandom)} : i[0] ? 16'h0000 : i[1] ? 16'hd3ff : 16'hd400);
        tally_and_finish();
    end
endmodule
bind bbe_exec bbe_exec_props chk_u (.ref_clk, .rst_n, .opcode, .q_phase, .pc, .discard, .file_port);
